// >>> core/ucp_consts.svh
// ucp_consts.svh: register offsets, field positions, reset values and counts
// for one serial channel with its pin interface.
// assumes: included by its bare name; APB byte addresses, one 32-bit word each.
// Function
// [R01] With the interrupt-output control bit set, the interrupt pin is driven and auxiliary output two is low.
// [R02] With that bit clear (the reset value), the interrupt pin floats and auxiliary output two is high.
// [R03] An active-low transmitter-ready pin shows whether the transmit buffer can take a byte.
// [R04] An active-low receiver-ready pin shows whether a received byte waits in the holding register.
// [R05] With infrared mode off, the serial output is a plain line that is high in reset and when idle.
// [R06] With infrared mode on, the serial output carries encoder pulses and rests low with no data.
// [R07] In plain mode the remote end keeps the receive line high whenever it is not sending.
// [R08] In infrared mode the receive input rests low, and software may invert it ahead of the decoder.
// [R09] The active-low request-to-send pin is a general output that must be on before automatic flow control.
// [R10] The active-low clear-to-send pin is a general input that can gate transmission automatically.
// [R11] The active-low terminal-ready pin is a general output under software control.
// [R12] The set-ready, carrier-detect and ring inputs are only readable and affect nothing else.
// [R13] With the alternate bus style strapped, the interrupt pin becomes an active-low open-drain output.
// [R14] After reset request-to-send and terminal-ready stay high until software turns them on.
`ifndef UCP_CONSTS_SVH
`define UCP_CONSTS_SVH
`define UCP_OFS_DATA 8'h00
`define UCP_OFS_IER 8'h04
`define UCP_OFS_MCR 8'h08
`define UCP_OFS_EFR 8'h0C
`define UCP_OFS_LSR 8'h10
`define UCP_OFS_MSR 8'h14
`define UCP_OFS_DIV 8'h18
`define UCP_IER_RX_INT 0
`define UCP_IER_TX_INT 1
`define UCP_IER_AUTO_RTS 6
`define UCP_IER_AUTO_CTS 7
`define UCP_MCR_DTR 0
`define UCP_MCR_RTS 1
`define UCP_MCR_IRQ_EN 3
`define UCP_MCR_IR_INV 5
`define UCP_MCR_IR_MODE 6
`define UCP_EFR_AUTO_RTS 6
`define UCP_EFR_AUTO_CTS 7
`define UCP_LSR_RX_VALID 0
`define UCP_LSR_OVERRUN 1
`define UCP_LSR_FRAME 3
`define UCP_LSR_THR_EMPTY 5
`define UCP_LSR_TX_IDLE 6
`define UCP_REG_RST 8'h00
`define UCP_DIV_RST 16'h0001
`define UCP_SYNC_RST 6'h1F
`define UCP_OVS_LAST 4'hF
`define UCP_OVS_MID 4'h7
`define UCP_IR_PULSE 4'h3
`define UCP_BITS_LAST 3'h7
`endif

// >>> core/ucp_pkg.sv
// ucp_pkg: types shared by the channel modules.
// assumes: nothing.
package ucp_pkg;
    typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA, SER_STOP} ucp_ser_state_t;
endpackage : ucp_pkg

// >>> core/ucp_stream_if.sv
// ucp_stream_if: byte stream with valid and ready between channel modules.
// assumes: a byte moves at a rising edge where valid and ready are both high.
`timescale 1ns/1ns
interface ucp_stream_if;
    logic valid;
    logic ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : ucp_stream_if

// >>> core/ucp_fifo2.sv
// ucp_fifo2: two-entry byte buffer with valid and ready on both sides.
// assumes: one clock; the filling side holds its byte until ready.
`timescale 1ns/1ns
module ucp_fifo2 (
    input wire logic pclk,
    input wire logic presetn,
    ucp_stream_if.snk in_s,
    ucp_stream_if.src out_s
);
    logic [7:0] mem [0:1];
    logic wptr;
    logic rptr;
    logic [1:0] count;
    wire push = in_s.valid && in_s.ready;
    wire pop = out_s.valid && out_s.ready;

    // full and empty straight from the count
    assign in_s.ready = (count != 2'h2);
    assign out_s.valid = (count != 2'h0);
    assign out_s.data = mem[rptr];

    // pointers and occupancy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr <= 1'b0;
            rptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wptr <= ~wptr;
            end
            if (pop) begin
                rptr <= ~rptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    // storage, one write port per entry
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_entry
            always_ff @(posedge pclk) begin
                if (push && (wptr == 1'(gi))) begin
                    mem[gi] <= in_s.data;
                end
            end
        end
    endgenerate
endmodule : ucp_fifo2

// >>> core/ucp_tx.sv
// ucp_tx: 8N1 serialiser with optional infrared pulse encoding.
// assumes: tick is a one-cycle pulse at 16 times the bit rate.
`timescale 1ns/1ns
`include "ucp_consts.svh"
module ucp_tx (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic ir_mode,
    input wire logic start_ok,
    ucp_stream_if.snk in_s,
    output logic line,
    output logic busy
);
    ucp_pkg::ucp_ser_state_t state;
    logic [3:0] ovs;
    logic [2:0] bitn;
    logic [7:0] shift;
    wire idle = (state == ucp_pkg::SER_IDLE);
    wire bit_end = tick && (ovs == `UCP_OVS_LAST);
    wire bit_val = (state == ucp_pkg::SER_START) ? 1'b0 : (state == ucp_pkg::SER_DATA) ? shift[0] : 1'b1;

    // a new byte is taken only when idle and, with automatic clear-to-send on, clear to send
    assign in_s.ready = idle && start_ok; // [R10]
    assign busy = !idle;
    // plain line rests high; infrared sends a short high pulse per zero bit and rests low
    assign line = ir_mode ? (!bit_val && (ovs < `UCP_IR_PULSE)) : bit_val; // [R05] [R06]

    // frame sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ucp_pkg::SER_IDLE;
            ovs <= 4'h0;
            bitn <= 3'h0;
            shift <= 8'h00;
        end else begin
            ovs <= idle ? 4'h0 : (tick ? ovs + 4'h1 : ovs);
            unique case (state)
                ucp_pkg::SER_IDLE: if (in_s.valid && in_s.ready) begin
                    shift <= in_s.data;
                    state <= ucp_pkg::SER_START;
                end
                ucp_pkg::SER_START: if (bit_end) begin
                    bitn <= 3'h0;
                    state <= ucp_pkg::SER_DATA;
                end
                ucp_pkg::SER_DATA: if (bit_end) begin
                    shift <= {1'b1, shift[7:1]};
                    bitn <= bitn + 3'h1;
                    if (bitn == `UCP_BITS_LAST) begin
                        state <= ucp_pkg::SER_STOP;
                    end
                end
                ucp_pkg::SER_STOP: if (bit_end) begin
                    state <= ucp_pkg::SER_IDLE;
                end
            endcase
        end
    end
endmodule : ucp_tx

// >>> core/ucp_top.sv
// ucp_top: one serial channel with APB registers and its modem and status pins.
// assumes: pclk 50 MHz; all pins other than the APB are asynchronous.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ns
`include "ucp_consts.svh"
module ucp_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic chan_a_serial_out,
    input wire logic chan_a_serial_in,
    output logic chan_a_request_send_n,
    input wire logic chan_a_clear_send_n,
    output logic chan_a_terminal_ready_n,
    input wire logic chan_a_set_ready_n,
    input wire logic chan_a_carrier_detect_n,
    input wire logic chan_a_ring_indicate_n,
    output logic chan_a_tx_ready_n,
    output logic chan_a_rx_ready_n,
    output logic chan_a_irq_out,
    output logic chan_a_irq_oe,
    output logic chan_a_aux_out_two,
    input wire logic bus_style_alt
);
    logic [7:0] interrupt_enable_register;
    logic [7:0] modem_control_register;
    logic [7:0] enhanced_feature_register;
    logic [15:0] div;
    logic [15:0] bcnt;
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [3:0] ir_hold;
    ucp_pkg::ucp_ser_state_t rx_state;
    logic [3:0] rx_ovs;
    logic [2:0] rx_bitn;
    logic [7:0] rx_shift;
    logic [7:0] receive_holding_register;
    logic rx_valid;
    logic overrun;
    logic frame_err;
    logic [7:0] lsr_val;
    logic tx_line;
    logic tx_busy;

    ucp_stream_if push_s();
    ucp_stream_if pop_s();

    // pin inputs gathered for synchronising
    wire [5:0] pins_raw = {bus_style_alt, chan_a_ring_indicate_n, chan_a_carrier_detect_n,
        chan_a_set_ready_n, chan_a_clear_send_n, chan_a_serial_in};
    wire rx_pin = sync2[0];
    wire cts_n_s = sync2[1];
    wire dsr_n_s = sync2[2];
    wire cd_n_s = sync2[3];
    wire ri_n_s = sync2[4];
    wire alt_s = sync2[5];

    // two flip-flops on every asynchronous input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= `UCP_SYNC_RST;
            sync2 <= `UCP_SYNC_RST;
        end else begin
            sync1 <= pins_raw;
            sync2 <= sync1;
        end
    end

    // APB decode
    wire acc = psel && penable;
    wire fire = acc && pready;
    wire wr_fire = fire && pwrite;
    wire rd_fire = fire && !pwrite;
    wire sel_data = (paddr == `UCP_OFS_DATA);
    wire sel_ier = (paddr == `UCP_OFS_IER);
    wire sel_mcr = (paddr == `UCP_OFS_MCR);
    wire sel_efr = (paddr == `UCP_OFS_EFR);
    wire sel_lsr = (paddr == `UCP_OFS_LSR);
    wire sel_msr = (paddr == `UCP_OFS_MSR);
    wire sel_div = (paddr == `UCP_OFS_DIV);
    wire mapped = sel_data || sel_ier || sel_mcr || sel_efr || sel_lsr || sel_msr || sel_div;
    // a data write waits in the access phase while the transmit buffer is full
    wire acc_ok = !(sel_data && pwrite && !push_s.ready);

    // control fields
    wire ir_mode = modem_control_register[`UCP_MCR_IR_MODE];
    wire ir_inv = modem_control_register[`UCP_MCR_IR_INV];
    wire irq_en = modem_control_register[`UCP_MCR_IRQ_EN];
    wire auto_rts = enhanced_feature_register[`UCP_EFR_AUTO_RTS] && interrupt_enable_register[`UCP_IER_AUTO_RTS];
    wire auto_cts = enhanced_feature_register[`UCP_EFR_AUTO_CTS] && interrupt_enable_register[`UCP_IER_AUTO_CTS];
    wire thr_empty = !pop_s.valid;
    wire tx_idle = thr_empty && !tx_busy;
    wire tx_start_ok = !auto_cts || !cts_n_s; // [R10]
    wire irq_pend = (rx_valid && interrupt_enable_register[`UCP_IER_RX_INT]) || (thr_empty && interrupt_enable_register[`UCP_IER_TX_INT]);

    // line status assembled from channel state
    always_comb begin
        lsr_val = 8'h00;
        lsr_val[`UCP_LSR_RX_VALID] = rx_valid;
        lsr_val[`UCP_LSR_OVERRUN] = overrun;
        lsr_val[`UCP_LSR_FRAME] = frame_err;
        lsr_val[`UCP_LSR_THR_EMPTY] = thr_empty;
        lsr_val[`UCP_LSR_TX_IDLE] = tx_idle;
    end

    // modem status only reports the general inputs, active high in bits 7..4
    wire [7:0] msr_val = {!cd_n_s, !ri_n_s, !dsr_n_s, !cts_n_s, 4'h0}; // [R12]

    // read data select
    wire [7:0] rd_byte = sel_data ? receive_holding_register :
        sel_ier ? interrupt_enable_register :
        sel_mcr ? modem_control_register :
        sel_efr ? enhanced_feature_register :
        sel_lsr ? lsr_val :
        sel_msr ? msr_val : 8'h00;
    wire [31:0] rdata = sel_div ? {16'h0000, div} : {24'h000000, rd_byte};

    // bus answer: pready one cycle into the access phase unless stalled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= acc && !pready && acc_ok;
            if (acc && !pready) begin
                prdata <= rdata;
                pslverr <= !mapped;
            end
        end
    end

    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_enable_register <= `UCP_REG_RST;
            modem_control_register <= `UCP_REG_RST; // [R02] [R14]
            enhanced_feature_register <= `UCP_REG_RST;
            div <= `UCP_DIV_RST;
        end else if (wr_fire) begin
            if (sel_ier) begin
                interrupt_enable_register <= pwdata[7:0];
            end
            if (sel_mcr) begin
                modem_control_register <= pwdata[7:0];
            end
            if (sel_efr) begin
                enhanced_feature_register <= pwdata[7:0];
            end
            if (sel_div) begin
                div <= pwdata[15:0];
            end
        end
    end

    // 16x bit-rate enable; a divisor of zero acts as one
    wire [15:0] div_last = (div == 16'h0000) ? 16'h0000 : div - 16'h0001;
    wire tick = (bcnt == 16'h0000);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bcnt <= 16'h0000;
        end else begin
            bcnt <= tick ? div_last : bcnt - 16'h0001;
        end
    end

    // transmit path through the two-entry buffer
    assign push_s.valid = wr_fire && sel_data;
    assign push_s.data = pwdata[7:0];

    ucp_fifo2 u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_s(push_s),
        .out_s(pop_s)
    );

    ucp_tx u_tx (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .ir_mode(ir_mode),
        .start_ok(tx_start_ok),
        .in_s(pop_s),
        .line(tx_line),
        .busy(tx_busy)
    );

    // infrared decode: optional inversion, then each pulse marks one zero bit;
    // the hold loads only in infrared mode, so a plain line idling high
    // leaves nothing behind that would fake a start bit on a mode change
    wire ir_level = rx_pin ^ ir_inv; // [R08]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ir_hold <= 4'h0;
        end else if (ir_mode && ir_level) begin
            ir_hold <= `UCP_OVS_LAST; // [R08]
        end else if (tick && (ir_hold != 4'h0)) begin
            ir_hold <= ir_hold - 4'h1;
        end
    end
    // plain mode relies on the remote end idling the line high
    wire rx_bit = ir_mode ? (ir_hold == 4'h0) : rx_pin; // [R07]

    // receive sequencer, start bit checked at its middle
    wire rx_mid = tick && (rx_ovs == `UCP_OVS_MID);
    wire rx_sample = tick && (rx_ovs == `UCP_OVS_LAST);
    wire rx_stop = (rx_state == ucp_pkg::SER_STOP) && rx_sample;
    wire rx_store = rx_stop && rx_bit;
    wire rx_pop = rd_fire && sel_data;
    wire lsr_rd = rd_fire && sel_lsr;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= ucp_pkg::SER_IDLE;
            rx_ovs <= 4'h0;
            rx_bitn <= 3'h0;
            rx_shift <= 8'h00;
        end else begin
            unique case (rx_state)
                ucp_pkg::SER_IDLE: begin
                    rx_ovs <= 4'h0;
                    if (tick && !rx_bit) begin
                        rx_state <= ucp_pkg::SER_START;
                    end
                end
                ucp_pkg::SER_START: if (rx_mid) begin
                    rx_ovs <= 4'h0;
                    rx_bitn <= 3'h0;
                    rx_state <= rx_bit ? ucp_pkg::SER_IDLE : ucp_pkg::SER_DATA;
                end else if (tick) begin
                    rx_ovs <= rx_ovs + 4'h1;
                end
                ucp_pkg::SER_DATA: if (tick) begin
                    rx_ovs <= rx_ovs + 4'h1;
                    if (rx_sample) begin
                        rx_shift <= {rx_bit, rx_shift[7:1]};
                        rx_bitn <= rx_bitn + 3'h1;
                        if (rx_bitn == `UCP_BITS_LAST) begin
                            rx_state <= ucp_pkg::SER_STOP;
                        end
                    end
                end
                ucp_pkg::SER_STOP: if (tick) begin
                    rx_ovs <= rx_ovs + 4'h1;
                    if (rx_sample) begin
                        rx_state <= ucp_pkg::SER_IDLE;
                    end
                end
            endcase
        end
    end

    // holding register and error flags; a new event wins over a clearing read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_holding_register <= 8'h00;
            rx_valid <= 1'b0;
            overrun <= 1'b0;
            frame_err <= 1'b0;
        end else begin
            if (rx_store && (!rx_valid || rx_pop)) begin
                receive_holding_register <= rx_shift;
            end
            if (rx_store) begin
                rx_valid <= 1'b1;
            end else if (rx_pop) begin
                rx_valid <= 1'b0;
            end
            if (rx_store && rx_valid && !rx_pop) begin
                overrun <= 1'b1;
            end else if (lsr_rd) begin
                overrun <= 1'b0;
            end
            if (rx_stop && !rx_bit) begin
                frame_err <= 1'b1;
            end else if (lsr_rd) begin
                frame_err <= 1'b0;
            end
        end
    end

    // registered pin outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_a_serial_out <= 1'b1; // [R05]
            chan_a_request_send_n <= 1'b1; // [R14]
            chan_a_terminal_ready_n <= 1'b1; // [R14]
            chan_a_tx_ready_n <= 1'b1;
            chan_a_rx_ready_n <= 1'b1;
            chan_a_irq_out <= 1'b0;
            chan_a_irq_oe <= 1'b0; // [R02]
            chan_a_aux_out_two <= 1'b1; // [R02]
        end else begin
            chan_a_serial_out <= tx_line; // [R05] [R06]
            chan_a_request_send_n <= !modem_control_register[`UCP_MCR_RTS] || (auto_rts && rx_valid); // [R09]
            chan_a_terminal_ready_n <= !modem_control_register[`UCP_MCR_DTR]; // [R11]
            chan_a_tx_ready_n <= !push_s.ready; // [R03]
            chan_a_rx_ready_n <= !rx_valid; // [R04]
            chan_a_irq_out <= alt_s ? 1'b0 : irq_pend; // [R13]
            chan_a_irq_oe <= alt_s ? irq_pend : irq_en; // [R01] [R13]
            chan_a_aux_out_two <= !irq_en; // [R01] [R02]
        end
    end

    // checks on the pin behaviour
    default clocking ast_clk @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence seq_rts_write_on;
        wr_fire && sel_mcr && pwdata[`UCP_MCR_RTS] && !auto_rts;
    endsequence

    AST_IRQ_ACTIVE: assert property ((irq_en && !alt_s) |=> (chan_a_irq_oe && !chan_a_aux_out_two)) // [R01]
        else $error("interrupt pin not driven with enable set");
    AST_IRQ_FLOAT: assert property ((!irq_en && !alt_s) |=> (!chan_a_irq_oe && chan_a_aux_out_two)) // [R02]
        else $error("interrupt pin driven with enable clear");
    AST_TX_READY: assert property (!push_s.ready |=> chan_a_tx_ready_n) // [R03]
        else $error("transmit ready shown while buffer full");
    AST_RX_READY: assert property (rx_store |=> ##1 !chan_a_rx_ready_n) // [R04]
        else $error("receive ready missing after a stored byte");
    AST_TX_IDLE_STD: assert property ((!ir_mode && !tx_busy) |=> chan_a_serial_out) // [R05]
        else $error("plain line not high when idle");
    AST_TX_IDLE_IR: assert property ((ir_mode && !tx_busy) |=> !chan_a_serial_out) // [R06]
        else $error("infrared line not low when idle");
    AST_IR_INVERT: assert property ((ir_mode && (rx_pin ^ ir_inv)) |=> (ir_hold == `UCP_OVS_LAST)) // [R08]
        else $error("infrared pulse not seen after polarity select");
    AST_RTS_AUTO: assert property ((auto_rts && rx_valid) |=> chan_a_request_send_n) // [R09]
        else $error("request to send kept on with receiver full");
    AST_RTS_SOFT: assert property (seq_rts_write_on |=> ##1 !chan_a_request_send_n) // [R09]
        else $error("request to send not on after control write");
    AST_CTS_HOLD: assert property ((auto_cts && cts_n_s && !tx_busy) |=> !tx_busy) // [R10]
        else $error("frame started without clear to send");
    AST_DTR: assert property (1'b1 |=> (chan_a_terminal_ready_n == !$past(modem_control_register[`UCP_MCR_DTR]))) // [R11]
        else $error("terminal ready does not follow control");
    AST_OPEN_DRAIN: assert property (alt_s |=> (!chan_a_irq_out && (chan_a_irq_oe == $past(irq_pend)))) // [R13]
        else $error("open-drain interrupt wrong");
    AST_RTS_RESET: assert property (!modem_control_register[`UCP_MCR_RTS] |=> chan_a_request_send_n) // [R14]
        else $error("request to send on while control bit clear");
endmodule : ucp_top

// >>> sim/ucp_remote.sv
// ucp_remote: far-end serial device, 8N1, 16 pclk per bit.
// assumes: channel divisor 1; frames are decoded on the plain line.
`timescale 1ns/1ns
module ucp_remote (
    input wire logic pclk,
    input wire logic rx_line,
    output logic tx_line
);
    logic [7:0] got_q[$];
    logic [7:0] sh;
    initial tx_line = 1'b1;
    // send one frame; the line rests high outside frames
    task automatic send(input logic [7:0] d);
        for (int i = 0; i < 10; i++) begin
            tx_line <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
            repeat (16) @(posedge pclk);
        end
    endtask : send
    // decode frames sent by the channel, sampling mid-bit
    always begin
        @(negedge rx_line);
        repeat (8) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge pclk);
            sh[i] = rx_line;
        end
        repeat (16) @(posedge pclk);
        got_q.push_back(sh);
    end
endmodule : ucp_remote

// >>> sim/test_uart_channel_pin_interface.sv
// test_uart_channel_pin_interface: self-checking bench for ucp_top.
// assumes: ucp_remote on the serial pins; divisor 1 gives 16 pclk per bit.
`timescale 1ns/1ns
`include "ucp_consts.svh"
module test_uart_channel_pin_interface;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, tx, rx, rts_n, dtr_n, txr_n, rxr_n, irq, irq_oe, aux;
    logic cts_n = 0, dsr_n = 1, cd_n = 1, ri_n = 1, alt = 0;
    logic [7:0] b;
    logic [7:0] exp_q[$];
    int fail_count = 0, n_compared = 0;
    always #10 pclk = ~pclk;
    ucp_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chan_a_serial_out(tx), .chan_a_serial_in(rx), .chan_a_request_send_n(rts_n),
        .chan_a_clear_send_n(cts_n), .chan_a_terminal_ready_n(dtr_n), .chan_a_set_ready_n(dsr_n),
        .chan_a_carrier_detect_n(cd_n), .chan_a_ring_indicate_n(ri_n), .chan_a_tx_ready_n(txr_n),
        .chan_a_rx_ready_n(rxr_n), .chan_a_irq_out(irq), .chan_a_irq_oe(irq_oe),
        .chan_a_aux_out_two(aux), .bus_style_alt(alt));
    ucp_remote rem_u (.pclk(pclk), .rx_line(tx), .tx_line(rx));
    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    // one APB transfer; waits for pready, then releases; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // wait for k frames at the remote end
    task automatic wait_rx(input int k);
        for (int n = 0; n < 5000 && rem_u.got_q.size() < k; n++) @(posedge pclk);
        check(rem_u.got_q.size() >= k, 1);
    endtask : wait_rx
    // set the modem control bits and check the pins they drive
    task automatic mcr_pins(input logic [7:0] m);
        apb(1, `UCP_OFS_MCR, {24'h0, m});
        repeat (2) @(posedge pclk);
        check(dtr_n, !m[0]);
        check(rts_n, !m[1]);
        check(irq_oe, m[3]);
        check(aux, !m[3]);
    endtask : mcr_pins
    initial begin
        #200000;
        fail_count++;
        finish_test();
    end
    initial begin
        void'($urandom(45));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        check(tx, 1);
        check(rts_n, 1);
        check(dtr_n, 1);
        check(aux, 1);
        check(irq_oe, 0);
        repeat (3) @(posedge pclk);
        apb(0, 8'h1C, 0);
        check(er, 1);
        check(rd, 0);
        apb(1, `UCP_OFS_DIV, 1);
        apb(1, `UCP_OFS_IER, 32'h02);
        for (int i = 0; i < 8; i++) mcr_pins({4'h0, i[2], 1'b0, i[1:0]});
        apb(1, `UCP_OFS_MCR, 0);
        check(txr_n, 0);
        // four bytes back to back; the last write stalls on a full buffer
        for (int i = 0; i < 4; i++) begin
            if (i == 3) begin
                repeat (2) @(posedge pclk);
                check(txr_n, 1);
            end
            b = 8'($urandom);
            exp_q.push_back(b);
            apb(1, `UCP_OFS_DATA, {24'h0, b});
        end
        wait_rx(4);
        while (exp_q.size() > 0) check(rem_u.got_q.pop_front(), exp_q.pop_front());
        // receive with automatic flow control on
        dsr_n <= 1'($urandom);
        cd_n <= 1'($urandom);
        ri_n <= 1'($urandom);
        apb(1, `UCP_OFS_EFR, 32'hC0);
        apb(1, `UCP_OFS_IER, 32'hC0);
        mcr_pins(8'h02);
        b = 8'($urandom);
        rem_u.send(b);
        for (int n = 0; n < 100 && rxr_n !== 1'b0; n++) @(posedge pclk);
        repeat (2) @(posedge pclk);
        check(rxr_n, 0);
        check(rts_n, 1);
        apb(0, `UCP_OFS_DATA, 0);
        check(rd, {24'h0, b});
        apb(0, `UCP_OFS_MSR, 0);
        check(rd[7:5], {!cd_n, !ri_n, !dsr_n});
        check(rxr_n, 1);
        check(rts_n, 0);
        // clear-to-send off holds a new frame back
        cts_n <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1, `UCP_OFS_DATA, 32'hA5);
        repeat (100) @(posedge pclk);
        check(tx, 1);
        cts_n <= 1'b0;
        wait_rx(1);
        check(rem_u.got_q.pop_front(), 8'hA5);
        // open-drain interrupt with the alternate strap
        apb(1, `UCP_OFS_IER, 32'h02);
        alt <= 1'b1;
        repeat (5) @(posedge pclk);
        check(irq, 0);
        check(irq_oe, 1);
        apb(1, `UCP_OFS_IER, 0);
        repeat (2) @(posedge pclk);
        check(irq_oe, 0);
        alt <= 1'b0;
        // infrared mode with inverted receive: high rest is no data
        apb(1, `UCP_OFS_MCR, 32'h60);
        repeat (2) @(posedge pclk);
        check(tx, 0);
        repeat (300) @(posedge pclk);
        check(rxr_n, 1);
        apb(1, `UCP_OFS_DATA, 0);
        for (int n = 0; n < 40 && tx !== 1'b1; n++) @(posedge pclk);
        check(tx, 1);
        // a low level on the inverted input is a pulse and must be decoded as data
        rem_u.send(8'hFF);
        for (int n = 0; n < 100 && rxr_n !== 1'b0; n++) @(posedge pclk);
        check(rxr_n, 0);
        finish_test();
    end
endmodule : test_uart_channel_pin_interface
